// File: hw/anpr_pkg.sv
// Summary of operation
// RQ1: reserved bit 14 of advertisement reads zero
// RQ2: software writes defaults into reserved bits
// RQ3: bit 14 writable only with override set
// RQ4: bits 12:10 writable only with override set
// RQ5: reserved bits 12:10 read as zero
// RQ6: remote fault bit follows local link fault
// RQ7: remote fault sent in code word
// RQ8: ability bits advertise supported technologies
// RQ9: 100Base-T4 ability bit held at zero
// RQ10: negotiation off: speed, duplex from control
// RQ11: negotiation on: advertise bits 8:5, default one
// RQ12: status capabilities ignore ability field
// RQ13: software rewrites abilities then restarts
// RQ14: selector field sent, default 00001
// RQ15: partner register loaded from received word
// RQ16: partner data valid after completion status
// RQ17: partner next page bit from received word
// RQ18: partner acknowledge bit from received word
// RQ19: partner remote fault from received word
// RQ20: partner bits 9, 12:10 read zero
// RQ21: partner bits 8:5 report partner abilities
// RQ22: partner selector fixed 00001, resets zero
//
// Purpose : constants and carriers of the advertisement/partner bank
// Assumes : 16-bit management registers, 5-bit register index
// Notes   : one package shared by the register bank
package anpr_pkg;

    // =====================================================================
    // register map
    localparam logic [4:0]  ANPR_OFS_CONTROL  = 5'h00;
    localparam logic [4:0]  ANPR_OFS_STATUS   = 5'h01;
    localparam logic [4:0]  ANPR_OFS_ADVERT   = 5'h04;
    localparam logic [4:0]  ANPR_OFS_PARTNER  = 5'h05;
    localparam logic [4:0]  ANPR_OFS_EXTCTRL  = 5'h10;

    // =====================================================================
    // field positions
    localparam int ANPR_CTL_SPEED_BIT    = 13;
    localparam int ANPR_CTL_AN_EN_BIT    = 12;
    localparam int ANPR_CTL_RESTART_BIT  = 9;
    localparam int ANPR_CTL_DUPLEX_BIT   = 8;
    localparam int ANPR_EXT_OVERRIDE_BIT = 15;
    localparam int ANPR_STS_AN_DONE_BIT  = 5;
    localparam int ANPR_NP_BIT           = 15;
    localparam int ANPR_ACK_BIT          = 14;
    localparam int ANPR_RF_BIT           = 13;
    localparam int ANPR_RSV_HI           = 12;
    localparam int ANPR_RSV_LO           = 10;
    localparam int ANPR_T4_BIT           = 9;
    localparam int ANPR_ABIL_HI          = 8;
    localparam int ANPR_ABIL_LO          = 5;
    localparam int ANPR_SEL_HI           = 4;
    localparam int ANPR_SEL_LO           = 0;

    // =====================================================================
    // reset values
    localparam logic [3:0]  ANPR_ABIL_RST     = 4'hF;
    localparam logic [4:0]  ANPR_SEL_RST      = 5'h01;
    localparam logic [2:0]  ANPR_RSV_RST      = 3'h0;
    localparam logic [15:0] ANPR_PARTNER_RST  = 16'h0000;
    localparam logic        ANPR_AN_EN_RST    = 1'b1;
    localparam logic        ANPR_SPEED_RST    = 1'b1;
    localparam logic        ANPR_DUPLEX_RST   = 1'b0;
    // fixed capability bits of the status register (10/100, half/full, AN)
    localparam logic [15:0] ANPR_STATUS_CAPS  = 16'h7808;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } anpr_bus_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } anpr_lcw_type;

    typedef struct packed {
        logic        speed_sel;
        logic        an_enable;
        logic        duplex_sel;
        logic        override;
        logic        adv_np;
        logic        adv_ack_rsv;
        logic [2:0]  adv_rsv;
        logic [3:0]  adv_abil;
        logic [4:0]  adv_sel;
        logic [15:0] partner;
        logic [15:0] rdata;
        logic [15:0] tx_lcw;
        logic        restart;
        logic        speed_100;
        logic        full_duplex;
        logic        an_active;
    } anpr_state_type;

endpackage : anpr_pkg

// File: hw/anpr_regs.sv
// Purpose : advertisement and link partner ability registers
// Assumes : management port and link logic on I_CLOCK
// Notes   : read data appear in the cycle after the read strobe
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module anpr_regs
    import anpr_pkg::*;
(
    // clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST,
    // management port
    input  wire logic [4:0]  I_ADDR,
    input  wire logic [15:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [15:0] O_RDATA,
    // negotiation logic
    input  wire logic        I_LINK_FAULT,
    input  wire logic        I_AN_COMPLETE,
    input  wire logic        I_RX_LCW_VALID,
    input  wire logic [15:0] I_RX_LCW,
    output logic      [15:0] O_TX_LCW,
    output logic             O_AN_ENABLE,
    output logic             O_AN_RESTART,
    // forced mode
    output logic             O_SPEED_100,
    output logic             O_FULL_DUPLEX
);

    // =====================================================================
    // state
    anpr_bus_type   bus;
    anpr_lcw_type   rx;
    anpr_state_type st_ff;
    anpr_state_type nxt_st;

    assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign rx  = '{valid: I_RX_LCW_VALID, word: I_RX_LCW};

    // =====================================================================
    // next state
    always_comb begin
        logic        wr_ctl;
        logic        wr_adv;
        logic        wr_ext;
        logic [15:0] adv_view;
        logic [15:0] ctl_view;
        logic [15:0] sts_view;
        logic [15:0] ext_view;
        logic [15:0] lcw;
        wr_ctl   = 1'b0;
        wr_adv   = 1'b0;
        wr_ext   = 1'b0;
        adv_view = 16'h0000;
        ctl_view = 16'h0000;
        sts_view = 16'h0000;
        ext_view = 16'h0000;
        lcw      = 16'h0000;
        nxt_st   = st_ff;

        wr_ctl = bus.wr && (bus.addr == ANPR_OFS_CONTROL);
        wr_adv = bus.wr && (bus.addr == ANPR_OFS_ADVERT);
        wr_ext = bus.wr && (bus.addr == ANPR_OFS_EXTCTRL);

        // control register: enable, speed, duplex, self-clearing restart
        nxt_st.restart = 1'b0;
        if (wr_ctl) begin
            nxt_st.speed_sel  = bus.wdata[ANPR_CTL_SPEED_BIT];
            nxt_st.an_enable  = bus.wdata[ANPR_CTL_AN_EN_BIT];
            nxt_st.duplex_sel = bus.wdata[ANPR_CTL_DUPLEX_BIT];
            nxt_st.restart    = bus.wdata[ANPR_CTL_RESTART_BIT];
        end
        if (wr_ext) begin
            nxt_st.override = bus.wdata[ANPR_EXT_OVERRIDE_BIT];
        end

        // advertisement register
        if (wr_adv) begin
            nxt_st.adv_np   = bus.wdata[ANPR_NP_BIT];
            nxt_st.adv_abil = bus.wdata[ANPR_ABIL_HI:ANPR_ABIL_LO]; // see RQ8
            if (st_ff.override) begin
                nxt_st.adv_ack_rsv = bus.wdata[ANPR_ACK_BIT]; // see RQ3
                nxt_st.adv_rsv =
                    bus.wdata[ANPR_RSV_HI:ANPR_RSV_LO]; // see RQ4
                nxt_st.adv_sel = bus.wdata[ANPR_SEL_HI:ANPR_SEL_LO];
            end
        end

        // partner register filled from the received code word
        if (rx.valid) begin
            nxt_st.partner = 16'h0000;                     // see RQ20
            nxt_st.partner[ANPR_NP_BIT]  = rx.word[ANPR_NP_BIT];  // see RQ17
            nxt_st.partner[ANPR_ACK_BIT] = rx.word[ANPR_ACK_BIT]; // see RQ18
            nxt_st.partner[ANPR_RF_BIT]  = rx.word[ANPR_RF_BIT];  // see RQ19
            nxt_st.partner[ANPR_ABIL_HI:ANPR_ABIL_LO] =
                rx.word[ANPR_ABIL_HI:ANPR_ABIL_LO];        // see RQ15 RQ21
            nxt_st.partner[ANPR_SEL_HI:ANPR_SEL_LO] = ANPR_SEL_RST; // see RQ22
        end

        // read views
        adv_view[ANPR_NP_BIT] = st_ff.adv_np;
        adv_view[ANPR_ACK_BIT] = 1'b0;                     // see RQ1
        adv_view[ANPR_RF_BIT] = I_LINK_FAULT;              // see RQ6
        adv_view[ANPR_RSV_HI:ANPR_RSV_LO] = 3'h0;          // see RQ5
        adv_view[ANPR_T4_BIT] = 1'b0;                      // see RQ9
        adv_view[ANPR_ABIL_HI:ANPR_ABIL_LO] = st_ff.adv_abil;
        adv_view[ANPR_SEL_HI:ANPR_SEL_LO] = st_ff.adv_sel;

        ctl_view[ANPR_CTL_SPEED_BIT]  = st_ff.speed_sel;
        ctl_view[ANPR_CTL_AN_EN_BIT]  = st_ff.an_enable;
        ctl_view[ANPR_CTL_DUPLEX_BIT] = st_ff.duplex_sel;
        // capabilities are fixed, never taken from the ability field
        sts_view = ANPR_STATUS_CAPS;                       // see RQ12
        sts_view[ANPR_STS_AN_DONE_BIT] = I_AN_COMPLETE;
        ext_view[ANPR_EXT_OVERRIDE_BIT] = st_ff.override;

        nxt_st.rdata = 16'h0000;
        if (bus.rd) begin
            case (bus.addr)
                ANPR_OFS_CONTROL: begin
                    nxt_st.rdata = ctl_view;
                end
                ANPR_OFS_STATUS: begin
                    nxt_st.rdata = sts_view;
                end
                ANPR_OFS_ADVERT: begin
                    nxt_st.rdata = adv_view;
                end
                ANPR_OFS_PARTNER: begin
                    nxt_st.rdata = st_ff.partner;
                end
                ANPR_OFS_EXTCTRL: begin
                    nxt_st.rdata = ext_view;
                end
                default: begin
                    nxt_st.rdata = 16'h0000;
                end
            endcase
        end

        // transmitted code word, only while negotiation is enabled
        lcw[ANPR_NP_BIT] = st_ff.adv_np;
        lcw[ANPR_RF_BIT] = I_LINK_FAULT;                   // see RQ7
        lcw[ANPR_ABIL_HI:ANPR_ABIL_LO] = st_ff.adv_abil;  // see RQ11
        lcw[ANPR_SEL_HI:ANPR_SEL_LO] = st_ff.adv_sel;     // see RQ14
        nxt_st.tx_lcw    = st_ff.an_enable ? lcw : 16'h0000;
        nxt_st.an_active = st_ff.an_enable;

        // forced mode follows the control bits when negotiation is off
        if (!st_ff.an_enable) begin
            nxt_st.speed_100   = st_ff.speed_sel;          // see RQ10
            nxt_st.full_duplex = st_ff.duplex_sel;         // see RQ10
        end else begin
            nxt_st.speed_100   = st_ff.speed_100;
            nxt_st.full_duplex = st_ff.full_duplex;
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            st_ff.speed_sel   <= ANPR_SPEED_RST;
            st_ff.an_enable   <= ANPR_AN_EN_RST;
            st_ff.duplex_sel  <= ANPR_DUPLEX_RST;
            st_ff.override    <= 1'b0;
            st_ff.adv_np      <= 1'b0;
            st_ff.adv_ack_rsv <= 1'b0;
            st_ff.adv_rsv     <= ANPR_RSV_RST;
            st_ff.adv_abil    <= ANPR_ABIL_RST;            // see RQ11
            st_ff.adv_sel     <= ANPR_SEL_RST;
            st_ff.partner     <= ANPR_PARTNER_RST;         // see RQ22
            st_ff.rdata       <= 16'h0000;
            st_ff.tx_lcw      <= 16'h0000;
            st_ff.restart     <= 1'b0;
            st_ff.speed_100   <= ANPR_SPEED_RST;
            st_ff.full_duplex <= ANPR_DUPLEX_RST;
            st_ff.an_active   <= ANPR_AN_EN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================================
    // outputs
    assign O_RDATA       = st_ff.rdata;
    assign O_TX_LCW      = st_ff.tx_lcw;
    assign O_AN_ENABLE   = st_ff.an_active;
    assign O_AN_RESTART  = st_ff.restart;
    assign O_SPEED_100   = st_ff.speed_100;
    assign O_FULL_DUPLEX = st_ff.full_duplex;

endmodule : anpr_regs

// File: sim/anpr_peer.sv
// Purpose: remote link partner handing over received code words
// Assumes: one word a request, valid for one cycle
// Notes  : between words the lines invert every cycle, starting from the last word
`timescale 1ns/10ps
module anpr_peer
    import anpr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic [15:0] i_word,
    output anpr_lcw_type     o_lcw
);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_lcw <= '0;
        end else begin
            o_lcw.valid <= i_go;
            o_lcw.word  <= i_go ? i_word : ~o_lcw.word;
        end
    end
endmodule : anpr_peer

// File: sim/anpr_props.sv
// Purpose: port checker of the advertisement/partner bank
// Assumes: one clock, async reset high
// Notes  : bound to every anpr_regs instance
`timescale 1ns/10ps
module anpr_props
    import anpr_pkg::*;
(
    // clock, reset
    input wire logic        I_CLOCK,
    input wire logic        I_RST,
    // watched ports
    input wire logic [4:0]  I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [15:0] O_RDATA,
    input wire logic        I_LINK_FAULT,
    input wire logic        I_AN_COMPLETE,
    input wire logic        I_RX_LCW_VALID,
    input wire logic [15:0] I_RX_LCW,
    input wire logic [15:0] O_TX_LCW,
    input wire logic        O_AN_ENABLE,
    input wire logic        O_AN_RESTART,
    input wire logic        O_SPEED_100,
    input wire logic        O_FULL_DUPLEX
);
    logic [15:0] lcw_ff;
    logic        rd_adv, rd_par, rd_sts, wr_rst;
    logic        spd_sel_ff, dup_sel_ff;
    assign rd_adv = I_RD && (I_ADDR == ANPR_OFS_ADVERT);
    assign rd_par = I_RD && (I_ADDR == ANPR_OFS_PARTNER);
    assign rd_sts = I_RD && (I_ADDR == ANPR_OFS_STATUS);
    assign wr_rst = I_WR && (I_ADDR == ANPR_OFS_CONTROL)
                    && I_WDATA[ANPR_CTL_RESTART_BIT];
    // shadow of the forced speed and duplex selects
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            spd_sel_ff <= ANPR_SPEED_RST;
            dup_sel_ff <= ANPR_DUPLEX_RST;
        end else if (I_WR && (I_ADDR == ANPR_OFS_CONTROL)) begin
            spd_sel_ff <= I_WDATA[ANPR_CTL_SPEED_BIT];
            dup_sel_ff <= I_WDATA[ANPR_CTL_DUPLEX_BIT];
        end
    end
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            lcw_ff <= 16'h0000;
        end else if (I_RX_LCW_VALID) begin
            lcw_ff <= I_RX_LCW;
        end
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // ==================================================================
    // checks
    sequence s_word;
        I_RX_LCW_VALID ##1 (rd_par && !I_RX_LCW_VALID);
    endsequence
    a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
        else $error("read data not idle");
    a_adv_rsv: assert property ($past(rd_adv) |->
        !O_RDATA[14] && O_RDATA[12:9] == 4'h0) else $error("adv reserved");
    a_adv_fault: assert property ($past(rd_adv) |->
        O_RDATA[13] == $past(I_LINK_FAULT)) else $error("adv fault bit");
    a_tx_rsv: assert property (
        !O_TX_LCW[14] && O_TX_LCW[12:9] == 4'h0)
        else $error("tx reserved bits");
    a_tx_fault: assert property (
        O_AN_ENABLE && $past(O_AN_ENABLE) |->
        O_TX_LCW[13] == $past(I_LINK_FAULT)) else $error("tx fault bit");
    a_tx_off: assert property (
        !O_AN_ENABLE && !$past(O_AN_ENABLE) |->
        O_TX_LCW == 16'h0000) else $error("tx word while off");
    a_forced_mode: assert property (!O_AN_ENABLE |->
        O_SPEED_100 == $past(spd_sel_ff)
        && O_FULL_DUPLEX == $past(dup_sel_ff)) else $error("forced mode");
    a_par_rsv: assert property ($past(rd_par) |->
        O_RDATA[12:9] == 4'h0 && O_RDATA[4:1] == 4'h0) else $error("par");
    a_par_load: assert property (s_word |=>
        O_RDATA == {lcw_ff[15:13], 4'h0, lcw_ff[8:5], 5'h01})
        else $error("partner load");
    a_restart_pulse: assert property (
        O_AN_RESTART == $past(wr_rst)) else $error("restart pulse");
    a_status_caps: assert property ($past(rd_sts) |->
        O_RDATA[15:6] == ANPR_STATUS_CAPS[15:6] && O_RDATA[4:0] == 5'h08
        && O_RDATA[5] == $past(I_AN_COMPLETE)) else $error("status");
endmodule : anpr_props
bind anpr_regs anpr_props u_props (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .I_LINK_FAULT(I_LINK_FAULT),
    .I_AN_COMPLETE(I_AN_COMPLETE), .I_RX_LCW_VALID(I_RX_LCW_VALID),
    .I_RX_LCW(I_RX_LCW), .O_TX_LCW(O_TX_LCW), .O_AN_ENABLE(O_AN_ENABLE),
    .O_AN_RESTART(O_AN_RESTART), .O_SPEED_100(O_SPEED_100),
    .O_FULL_DUPLEX(O_FULL_DUPLEX));

// File: sim/anpr_regs_tb.sv
// Purpose: self-checking bench of the advertisement/partner bank
// Assumes: 40 MHz clock, reset held 12 cycles
// Notes  : reads are scored by a monitor against a queue of notes
`timescale 1ns/10ps
module anpr_regs_tb
    import anpr_pkg::*;
();
    logic        clk = 0, rst = 1, m_wr = 0, m_rd = 0, fault = 0, done = 1;
    logic        go = 0, rd_seen = 0, an_en, restart, spd, dup;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000, word = 16'h0000, rdata, tx;
    logic [15:0] exp_q[$];
    anpr_lcw_type lcw;
    int          num_errors = 0, compares = 0;
    initial forever #12.5 clk = ~clk;
    anpr_regs dut (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(m_wr), .I_RD(m_rd), .O_RDATA(rdata),
        .I_LINK_FAULT(fault), .I_AN_COMPLETE(done),
        .I_RX_LCW_VALID(lcw.valid), .I_RX_LCW(lcw.word), .O_TX_LCW(tx),
        .O_AN_ENABLE(an_en), .O_AN_RESTART(restart), .O_SPEED_100(spd),
        .O_FULL_DUPLEX(dup));
    anpr_peer peer (.i_clk(clk), .i_rst(rst), .i_go(go), .i_word(word),
        .o_lcw(lcw));
    // ==================================================================
    // tasks
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        {m_wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        m_wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        {m_rd, addr} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge clk);
        m_rd <= 1'b0;
    endtask : bus_rd
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        {go, word} <= {1'b1, w};
        @(posedge clk);
        go <= 1'b0;
    endtask : send
    task automatic results();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    always @(posedge clk) rd_seen <= m_rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            chk("read data", exp_q.pop_front(), rdata);
        end
    end
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        results();
    end
    // ==================================================================
    // scenarios
    initial begin
        logic [15:0] d;
        void'($urandom(32'hffffca20));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus_rd(ANPR_OFS_ADVERT, 16'h01E1);
        bus_rd(ANPR_OFS_PARTNER, 16'h0000);
        bus_rd(ANPR_OFS_CONTROL, 16'h3000);
        bus_rd(5'h02, 16'h0000);
        bus_wr(ANPR_OFS_ADVERT, 16'hFFFF);
        bus_rd(ANPR_OFS_ADVERT, 16'h81E1);
        bus_wr(ANPR_OFS_EXTCTRL, 16'h8000);
        bus_rd(ANPR_OFS_EXTCTRL, 16'h8000);
        bus_wr(ANPR_OFS_ADVERT, 16'h7FFE);
        bus_rd(ANPR_OFS_ADVERT, 16'h01FE);
        chk("tx word", 16'h01FE, tx);
        bus_wr(ANPR_OFS_ADVERT, 16'h01E1);
        bus_wr(ANPR_OFS_EXTCTRL, 16'h0000);
        bus_rd(ANPR_OFS_EXTCTRL, 16'h0000);
        fault <= 1'b1;
        bus_rd(ANPR_OFS_ADVERT, 16'h21E1);
        chk("tx word", 16'h21E1, tx);
        fault <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            bus_wr(ANPR_OFS_ADVERT, d);
            bus_rd(ANPR_OFS_ADVERT, {d[15], 6'h00, d[8:5], 5'h01});
        end
        bus_wr(ANPR_OFS_ADVERT, 16'h01E1);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            send(d);
            bus_rd(ANPR_OFS_PARTNER,
                {d[15:13], 4'h0, d[8:5], 5'h01});
        end
        for (int k = 0; k < 2; k++) begin
            done <= k[0];
            bus_rd(ANPR_OFS_STATUS,
                ANPR_STATUS_CAPS | {k[0], 5'h00});
        end
        bus_wr(ANPR_OFS_CONTROL, 16'h0100);
        repeat (3) @(negedge clk);
        chk("tx word", 16'h0000, tx);
        chk("mode", 16'h0001, {13'h0, an_en, spd, dup});
        bus_wr(ANPR_OFS_CONTROL, 16'h3200);
        @(negedge clk);
        chk("restart", 16'h0001, {15'h0, restart});
        @(negedge clk);
        chk("tx word", 16'h01E1, tx);
        results();
    end
endmodule : anpr_regs_tb
